// ==== logic/tvd_defs.vh ====
`ifndef TVD_DEFS_VH
`define TVD_DEFS_VH
// ----------------------------------------------------------------
// Trellis decoder constants
// ----------------------------------------------------------------
// Coordinate width, two's complement
`define TVD_CW 16
// Traceback depth in windows and its last index
`define TVD_DEPTH 20
`define TVD_DEPTH_M1 5'd19
`define TVD_DEPTH_CNT 5'd20
// Survivor memory entries: depth times eight states
`define TVD_SURV_LAST 159
// Path metric width and reset values
`define TVD_PM_W 20
`define TVD_PM_ZERO 20'h00000
`define TVD_PM_INIT_HI 20'h07FFF
`define TVD_PM_MAX 20'hFFFFF
// Branch metric: squared distance shifted down, then saturated
`define TVD_BM_SHIFT 17
`define TVD_BM_MAX 16'hFFFF
// Constellation scaling: one unit is 2 to the 13th, +4 clips
`define TVD_UNIT_SHIFT 13
`define TVD_UNIT_POS4 4'h4
`define TVD_FULL_POS 16'h7FFF
// Next state, index {state,input}, one octal digit per entry
`define TVD_NS_TABLE 96'o76452103457630125467032167541230
// Encoder output, index {state low bits,input}, octal digits
`define TVD_OUT_TABLE 48'o7214361436507250
// Point per 5-bit code: {x unit, y unit} nibbles, code 31 first
`define TVD_PT_TABLE {64'hF4F030FC1C10D014, 64'hFE3EF23212D21EDE, \
  64'hE1ED212D2F23EFE3, 64'hCF0F034F41010DC1}
`endif

// ==== logic/tvd_pair_buf.v ====
`timescale 1ns/1ps
`default_nettype none
module tvd_pair_buf #(
  parameter W = 5
) (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  // ----------------------------------------------------------------
  // Two-entry FIFO in flip-flops
  // ----------------------------------------------------------------
  reg [W-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  // Ready only while a slot is free, so a stalled reader fills it
  assign in_ready = ce && (count != 2'd2);
  assign out_valid = ce && (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer, count and storage update
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
      mem[0] <= {W{1'b0}};
      mem[1] <= {W{1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end
endmodule
`default_nettype wire

// ==== logic/tvd_decoder.v ====
`timescale 1ns/1ps
`include "tvd_defs.vh"
`default_nettype none
// Summary of operation
// - Encoder model starts in state zero
// - State packs delay one as MSB
// - Two input bits, eight states, three outputs
// - Next state follows the fixed table
// - Output depends on state's low bits
// - Group index is code's leading three bits
// - Distance to nearest point per group
// - Eight-entry per-window group minimum table
// - Branch metric is group of branch output
// - Branch metrics refreshed every window
// - Trace shortest path, emit oldest branch
// - Output lags input by traceback depth
// - Coordinates are 16-bit, 8000 to 7FFF
// - Group point coordinates from fixed table
// - Start metrics: zero, others 07FFF
// - Add-compare-select over four incoming branches
// - Traceback depth is twenty windows
module tvd_decoder (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire coord_valid,
  input wire [15:0] coord_x,
  input wire [15:0] coord_y,
  output wire coord_ready,
  output wire sym_valid,
  output wire [4:0] sym_data,
  input wire sym_ready
);
  // ----------------------------------------------------------------
  // States and storage
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACS = 4'b0010;
  localparam [3:0] ST_TRACE = 4'b0100;
  localparam [3:0] ST_EMIT = 4'b1000;

  reg [3:0] state;
  reg [15:0] x_q;
  reg [15:0] y_q;
  reg [19:0] pm [0:7];
  // Survivor entry: {predecessor state, decided 5-bit code}
  reg [7:0] surv [0:`TVD_SURV_LAST];
  reg [4:0] wr_ptr;
  reg [4:0] last_ptr;
  reg [4:0] win_cnt;
  reg [4:0] tb_cnt;
  reg [4:0] tb_ptr;
  reg [2:0] tb_state;
  reg [4:0] tb_code;
  wire buf_ready;
  wire [15:0] gm [0:7];
  wire [4:0] gcode [0:7];
  wire [19:0] pm_n [0:7];
  wire [19:0] next_pm [0:7];
  wire [7:0] next_surv [0:7];
  reg [19:0] pm_min;
  reg [2:0] best_state;
  integer b;
  integer d;
  integer k;

  // ----------------------------------------------------------------
  // Encoder model and constellation tables
  // ----------------------------------------------------------------
  // Next state; state bit 2 is delay element one
  function [2:0] tvd_ns;
    input [2:0] s;
    input [1:0] i;
    reg [95:0] t;
    begin
      t = `TVD_NS_TABLE >> ({s, i} * 3);
      tvd_ns = t[2:0];
    end
  endfunction

  // Encoder output, three bits with the redundant one
  function [2:0] tvd_out;
    input [2:0] s;
    input [1:0] i;
    reg [47:0] t;
    begin
      t = `TVD_OUT_TABLE >> ({s[1:0], i} * 3);
      tvd_out = t[2:0];
    end
  endfunction

  // Unit coordinate to 16-bit scale; +4 clips to full scale
  function [15:0] tvd_unit;
    input [3:0] u;
    begin
      if (u == `TVD_UNIT_POS4)
        tvd_unit = `TVD_FULL_POS;
      else
        tvd_unit = {u[2:0], {`TVD_UNIT_SHIFT{1'b0}}};
    end
  endfunction

  // Squared distance from the sample to the point of code c
  function [15:0] tvd_dist;
    input [15:0] x;
    input [15:0] y;
    input [4:0] c;
    reg [255:0] t;
    reg [15:0] px;
    reg [15:0] py;
    reg signed [16:0] dx;
    reg signed [16:0] dy;
    reg signed [33:0] sqx;
    reg signed [33:0] sqy;
    reg [33:0] sum;
    begin
      t = `TVD_PT_TABLE >> {c, 3'b000};
      px = tvd_unit(t[7:4]);
      py = tvd_unit(t[3:0]);
      dx = $signed({x[15], x}) - $signed({px[15], px});
      dy = $signed({y[15], y}) - $signed({py[15], py});
      // Full-width squares; a 17-bit product would wrap
      sqx = dx * dx;
      sqy = dy * dy;
      sum = sqx + sqy;
      // Squared form keeps the same nearest point, no root needed
      if (sum[33])
        tvd_dist = `TVD_BM_MAX;
      else
        tvd_dist = sum[`TVD_BM_SHIFT+15:`TVD_BM_SHIFT];
    end
  endfunction

  // ----------------------------------------------------------------
  // Group minimum distances, one block per group
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : grp
      localparam [31:0] GW = g;
      localparam [2:0] GI = GW[2:0];
      wire [15:0] d0 = tvd_dist(x_q, y_q, {GI, 2'd0});
      wire [15:0] d1 = tvd_dist(x_q, y_q, {GI, 2'd1});
      wire [15:0] d2 = tvd_dist(x_q, y_q, {GI, 2'd2});
      wire [15:0] d3 = tvd_dist(x_q, y_q, {GI, 2'd3});
      wire s01 = d1 < d0;
      wire s23 = d3 < d2;
      wire [15:0] m01 = s01 ? d1 : d0;
      wire [15:0] m23 = s23 ? d3 : d2;
      wire sf = m23 < m01;
      // Entry g of the per-window table holds group g's minimum
      assign gm[g] = sf ? m23 : m01;
      assign gcode[g] = sf ? {GI, 1'b1, s23} : {GI, 1'b0, s01};
      // Normalise so the best survivor sits at zero, no overflow
      assign pm_n[g] = pm[g] - pm_min;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Add-compare-select, one block per destination state
  // ----------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : acs
      reg [19:0] best_m;
      reg [7:0] best_e;
      reg [20:0] cand;
      reg [2:0] lbl;
      integer s;
      integer i;
      // Scan all 32 branches, keep the four that end here
      always @* begin
        best_m = `TVD_PM_MAX;
        best_e = 8'h00;
        cand = 21'h00000;
        lbl = 3'd0;
        for (s = 0; s < 8; s = s + 1) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (tvd_ns(s[2:0], i[1:0]) == n) begin
              lbl = tvd_out(s[2:0], i[1:0]);
              cand = {1'b0, pm_n[s]} + {5'h00, gm[lbl]};
              if (cand[20])
                cand = {1'b0, `TVD_PM_MAX};
              if (cand[19:0] < best_m) begin
                best_m = cand[19:0];
                best_e = {s[2:0], gcode[lbl]};
              end
            end
          end
        end
      end
      assign next_pm[n] = best_m;
      assign next_surv[n] = best_e;
    end
  endgenerate

  // Smallest path metric and the state that holds it
  always @* begin
    pm_min = pm[0];
    best_state = 3'd0;
    for (b = 1; b < 8; b = b + 1) begin
      if (pm[b] < pm_min) begin
        pm_min = pm[b];
        best_state = b[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Handshakes and output buffer
  // ----------------------------------------------------------------
  // A strobe outside IDLE is ignored; the partner must watch ready
  assign coord_ready = ce && (state == ST_IDLE);

  tvd_pair_buf #(
    .W(5)
  ) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .in_valid(state == ST_EMIT),
    .in_data(tb_code),
    .in_ready(buf_ready),
    .out_valid(sym_valid),
    .out_data(sym_data),
    .out_ready(sym_ready)
  );

  // ----------------------------------------------------------------
  // Window sequencer and traceback
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      wr_ptr <= 5'd0;
      last_ptr <= 5'd0;
      win_cnt <= 5'd0;
      tb_cnt <= 5'd0;
      tb_ptr <= 5'd0;
      tb_state <= 3'd0;
      tb_code <= 5'd0;
      // Only state 000 starts cheap, so every path begins there
      for (d = 0; d < 8; d = d + 1) begin
        pm[d] <= (d == 0) ? `TVD_PM_ZERO : `TVD_PM_INIT_HI;
      end
      for (k = 0; k <= `TVD_SURV_LAST; k = k + 1) begin
        surv[k] <= 8'h00;
      end
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (coord_valid) begin
            x_q <= coord_x;
            y_q <= coord_y;
            state <= ST_ACS;
          end
        end
        ST_ACS: begin
          for (d = 0; d < 8; d = d + 1) begin
            pm[d] <= next_pm[d];
            surv[{wr_ptr, d[2:0]}] <= next_surv[d];
          end
          last_ptr <= wr_ptr;
          if (wr_ptr == `TVD_DEPTH_M1)
            wr_ptr <= 5'd0;
          else
            wr_ptr <= wr_ptr + 5'd1;
          if (win_cnt != `TVD_DEPTH_CNT)
            win_cnt <= win_cnt + 5'd1;
          // Decide only once a full depth of windows is stored
          if (win_cnt >= `TVD_DEPTH_M1) begin
            tb_cnt <= 5'd0;
            state <= ST_TRACE;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_TRACE: begin
          if (tb_cnt == 5'd0) begin
            tb_state <= best_state;
            tb_ptr <= last_ptr;
          end else begin
            tb_code <= surv[{tb_ptr, tb_state}][4:0];
            tb_state <= surv[{tb_ptr, tb_state}][7:5];
            if (tb_ptr == 5'd0)
              tb_ptr <= `TVD_DEPTH_M1;
            else
              tb_ptr <= tb_ptr - 5'd1;
          end
          // The last read is the oldest window's branch
          if (tb_cnt == `TVD_DEPTH_CNT)
            state <= ST_EMIT;
          tb_cnt <= tb_cnt + 5'd1;
        end
        ST_EMIT: begin
          // A stalled receiver holds us here; no symbol is dropped
          if (buf_ready)
            state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verif/tvd_decoder_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module tvd_decoder_properties (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic coord_valid,
  input wire logic [15:0] coord_x,
  input wire logic [15:0] coord_y,
  input wire logic coord_ready,
  input wire logic sym_valid,
  input wire logic [4:0] sym_data,
  input wire logic sym_ready
);
  // ----------------------------------------
  // Accepted samples, saturating at the depth
  // ----------------------------------------
  logic [4:0] taken;
  wire logic acc = ce && coord_valid && coord_ready;

  // Counter tells fill windows from steady ones
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      taken <= 5'h00;
    end else if (acc && taken != 5'h14) begin
      taken <= taken + 5'h01;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  ce_gate_a: assert property (!ce |-> !coord_ready && !sym_valid)
    else $error("outputs live with clock enable low");
  take_drop_a: assert property (acc |=> !coord_ready)
    else $error("ready stayed high after a sample");
  fill_ready_a: assert property (acc && taken < 5'h13
    |=> !coord_ready ##1 (coord_ready || !ce))
    else $error("fill window not two cycles");
  steady_busy_a: assert property (acc && taken >= 5'h13
    |-> ##23 !coord_ready)
    else $error("traceback finished too early");
  out_rise_a: assert property (acc && taken >= 5'h13 && !sym_valid
    |-> ##24 sym_valid)
    else $error("decision not out 24 cycles after sample");
  first_out_a: assert property (sym_valid |-> taken >= 5'h14)
    else $error("symbol before twenty windows");
  sym_hold_a: assert property (sym_valid && !sym_ready ##1 ce
    |-> sym_valid && $stable(sym_data))
    else $error("symbol dropped while stalled");
  rst_out_a: assert property (disable iff (1'b0)
    !nrst |-> !sym_valid && sym_data == 5'h00)
    else $error("output not cleared in reset");
endmodule
`default_nettype wire

// ==== verif/tvd_demod_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Demodulator stand-in
// ----------------------------------------
module tvd_demod_model (
  input wire logic clk_sys,
  input wire logic coord_ready,
  output logic coord_valid,
  output logic [15:0] coord_x,
  output logic [15:0] coord_y
);
  // Unit to fixed point; +4 clips to positive full scale
  function automatic logic [15:0] fx(input int u);
    fx = (u == 4) ? 16'h7FFF : 16'(u * 8192);
  endfunction

  // Lines idle low at time zero
  initial begin
    coord_valid = 1'b0;
    coord_x = 16'h0000;
    coord_y = 16'h0000;
  end

  // One pair per strobe, held until ready is seen at an edge
  task send(input int ux, input int uy);
    @(posedge clk_sys);
    coord_valid <= 1'b1;
    coord_x <= fx(ux);
    coord_y <= fx(uy);
    do @(posedge clk_sys); while (coord_ready !== 1'b1);
    coord_valid <= 1'b0;
    // Inverse after release, so a stale pair never looks valid
    coord_x <= ~coord_x;
    coord_y <= ~coord_y;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys;
  logic nrst;
  logic ce;
  logic sym_ready;
  logic coord_valid;
  logic [15:0] coord_x;
  logic [15:0] coord_y;
  logic coord_ready;
  logic sym_valid;
  logic [4:0] sym_data;
  int failures;
  int checked;
  logic [4:0] got[$];
  // Path 000-011-111-100-000, then zeros; codes expected back
  int px[4] = '{3, 1, 4, 2};
  int py[4] = '{2, 2, -1, 3};
  logic [4:0] pc[5] = '{5'h14, 5'h13, 5'h04, 5'h0A, 5'h00};

  tvd_decoder tvd_decoder_i (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .coord_valid(coord_valid),
    .coord_x(coord_x),
    .coord_y(coord_y),
    .coord_ready(coord_ready),
    .sym_valid(sym_valid),
    .sym_data(sym_data),
    .sym_ready(sym_ready)
  );

  tvd_demod_model tvd_demod_model_i (
    .clk_sys(clk_sys),
    .coord_ready(coord_ready),
    .coord_valid(coord_valid),
    .coord_x(coord_x),
    .coord_y(coord_y)
  );

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Record every symbol the receiver takes
  always @(posedge clk_sys) begin
    if (sym_valid && sym_ready && ce) begin
      got.push_back(sym_data);
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [4:0] seen, input logic [4:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH t=%0t got %h want %h", $time, seen, want);
    end
  endtask

  task push(input int n);
    if (n < 4) begin
      tvd_demod_model_i.send(px[n], py[n]);
    end else begin
      tvd_demod_model_i.send(-4, 1);
    end
  endtask

  // Bounded wait, then the decided codes in window order
  task drain;
    int k;
    k = 0;
    while (got.size() < 5 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    check(5'(got.size()), 5'h05);
    for (int i = 0; i < 5; i++) begin
      check(got[i], pc[i]);
    end
  endtask

  task close_out;
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Receiver stalls until the buffer is full and input backs up
  task path_stall;
    sym_ready <= 1'b0;
    for (int n = 0; n < 22; n++) begin
      push(n);
    end
    repeat (50) @(posedge clk_sys);
    check({4'h0, coord_ready}, 5'h00);
    check({4'h0, sym_valid}, 5'h01);
    check(sym_data, 5'h14);
    ce <= 1'b0;
    @(posedge clk_sys);
    #1 check({3'h0, coord_ready, sym_valid}, 5'h00);
    @(posedge clk_sys);
    ce <= 1'b1;
    sym_ready <= 1'b1;
    push(22);
    push(23);
    drain;
  endtask

  // Reset with a word buffered, then the same path decodes again
  task reset_rerun;
    sym_ready <= 1'b0;
    push(0);
    push(1);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check({4'h0, sym_valid}, 5'h00);
    @(posedge clk_sys);
    nrst <= 1'b1;
    sym_ready <= 1'b1;
    got.delete();
    for (int n = 0; n < 24; n++) begin
      push(n);
    end
    drain;
  endtask

  // Main sequence
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b1;
    ce = 1'b1;
    sym_ready = 1'b0;
    failures = 0;
    checked = 0;
    // A clean falling edge before the first clock clears every flop
    #1 nrst = 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    path_stall;
    reset_rerun;
    close_out;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule

bind tvd_decoder tvd_decoder_properties tvd_decoder_properties_i (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .ce(ce),
  .coord_valid(coord_valid),
  .coord_x(coord_x),
  .coord_y(coord_y),
  .coord_ready(coord_ready),
  .sym_valid(sym_valid),
  .sym_data(sym_data),
  .sym_ready(sym_ready)
);
`default_nettype wire
